//--- design/sfl_fifo.sv
// Byte FIFO with clear, capacity limit and fill level
`timescale 1ns/1ps
`default_nettype none
module sfl_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input  wire logic                          core_clk,
	input  wire logic                          rst_b,
	// Control
	input  wire logic                          clr,
	input  wire logic [sfl_pkg::SFL_LVL_W-1:0] cap,
	// Fill side
	input  wire logic                          push,
	input  wire logic [WIDTH-1:0]              push_data,
	// Drain side
	input  wire logic                          pop,
	output logic      [WIDTH-1:0]              head,
	// Occupancy
	output logic      [sfl_pkg::SFL_LVL_W-1:0] level,
	output logic                               full,
	output logic                               empty
);
	import sfl_pkg::*;
	localparam int PW = $clog2(DEPTH);
	localparam logic [SFL_LVL_W-1:0] DEPTH_L = SFL_LVL_W'(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0]               wptr;
		logic [PW-1:0]               rptr;
		logic [SFL_LVL_W-1:0]        lvl;
	} sfl_fifo_s;
	sfl_fifo_s st_ff;
	sfl_fifo_s nxt_st;
	logic      do_push;
	logic      do_pop;
	// Level field only reaches four
	if (DEPTH != 2 && DEPTH != 4) begin : g_bad_depth
		$error("sfl_fifo: DEPTH must be 2 or 4");
	end
	// Occupancy and head
	assign empty   = (st_ff.lvl == SFL_LVL_EMPTY);
	assign full    = (st_ff.lvl >= cap) || (st_ff.lvl == DEPTH_L);
	assign level   = st_ff.lvl;
	assign head    = st_ff.mem[st_ff.rptr];
	assign do_push = push && !full;
	assign do_pop  = pop && !empty;
	// Next state, clear beats traffic
	always_comb begin
		nxt_st = st_ff;
		if (clr) begin
			nxt_st.wptr = '0;
			nxt_st.rptr = '0;
			nxt_st.lvl  = SFL_LVL_EMPTY;
		end else begin
			if (do_push) begin
				nxt_st.mem[st_ff.wptr] = push_data;
				nxt_st.wptr = st_ff.wptr + 1'b1;
			end
			if (do_pop) begin
				nxt_st.rptr = st_ff.rptr + 1'b1;
			end
			if (do_push && !do_pop) begin
				nxt_st.lvl = st_ff.lvl + 3'h1;
			end else if (do_pop && !do_push) begin
				nxt_st.lvl = st_ff.lvl - 3'h1;
			end
		end
	end
	// State register
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
	a_fifo_lvl_cap: assert property (
		@(posedge core_clk) disable iff (!rst_b) st_ff.lvl <= DEPTH_L)
		else $error("fifo level above depth");
endmodule // sfl_fifo
`default_nettype wire

//--- design/sfl_irq.sv
// Sticky interrupt status, mask and level interrupt output
`timescale 1ns/1ps
`default_nettype none
module sfl_irq #(
	parameter int N = 4
) (
	// Clock and reset
	input  wire logic         core_clk,
	input  wire logic         rst_b,
	// Hardware events
	input  wire logic [N-1:0] set,
	// Software access
	input  wire logic         wr_stat,
	input  wire logic         wr_mask,
	input  wire logic [N-1:0] wdata,
	// State
	output logic      [N-1:0] stat,
	output logic      [N-1:0] mask,
	output logic              irq
);
	import sfl_pkg::*;
	typedef struct packed {
		logic [N-1:0] stat;
		logic [N-1:0] mask;
		logic         irq;
	} sfl_irq_s;
	sfl_irq_s st_ff;
	sfl_irq_s nxt_st;
	if (N < 1 || N > 32) begin : g_bad_n
		$error("sfl_irq: N must be 1 to 32");
	end
	// Write one to clear, a new event wins
	always_comb begin
		nxt_st      = st_ff;
		nxt_st.stat = set | (st_ff.stat & ~(wr_stat ? wdata : '0));
		if (wr_mask) begin
			nxt_st.mask = wdata;
		end
		nxt_st.irq = |(nxt_st.stat & nxt_st.mask);
	end
	// State register
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
	assign stat = st_ff.stat;
	assign mask = st_ff.mask;
	assign irq  = st_ff.irq;
endmodule // sfl_irq
`default_nettype wire

//--- design/sfl_top.sv
// Receive and transmit FIFO level, threshold and clear control
`timescale 1ns/1ps
`default_nettype none
module sfl_top #(
	parameter int DEPTH = 4
) (
	// Clock and reset
	input  wire logic                           core_clk,
	input  wire logic                           rst_b,
	// Register port
	input  wire logic [sfl_pkg::SFL_ADDR_W-1:0] reg_addr,
	input  wire logic [31:0]                    reg_wdata,
	input  wire logic                           reg_wr,
	input  wire logic                           reg_rd,
	output logic      [31:0]                    reg_rdata_ff,
	// Channel mode
	input  wire logic                           fifo_enable,
	input  wire logic                           full_duplex,
	input  wire logic                           nine_bit_mode,
	input  wire logic                           channel_run,
	input  wire logic                           idle_mode,
	input  wire logic                           run_in_idle,
	// Receive shift register side
	input  wire logic                           rx_push,
	input  wire logic [7:0]                     rx_push_data,
	// Transmit shift register side
	input  wire logic                           tx_pop,
	output logic      [7:0]                     tx_data_ff,
	output logic                                tx_ready_ff,
	// Interrupt
	output logic                                irq_ff
);
	import sfl_pkg::*;

	typedef struct packed {
		logic        rx_cmp;
		logic [1:0]  rx_thr;
		logic        tx_cmp;
		logic [1:0]  tx_thr;
		logic        rx_ovr;
		logic        tx_und;
		logic        rx_hit;
		logic        tx_hit;
		logic [31:0] rdata;
		logic [7:0]  tx_data;
		logic        tx_rdy;
	} sfl_top_s;

	localparam sfl_top_s TOP_RST = '{tx_und: SFL_TX_UND_RST, default: '0};

	sfl_top_s                 st_ff;
	sfl_top_s                 nxt_st;
	sfl_reg_e                 sel;
	logic                     wr_rx_cfg;
	logic                     wr_tx_cfg;
	logic                     wr_data;
	logic                     rd_data;
	logic                     rx_clr;
	logic                     tx_clr;
	logic                     fe;
	logic                     tx_stop;
	logic [SFL_LVL_W-1:0]     rx_cap;
	logic [SFL_LVL_W-1:0]     tx_cap;
	logic [SFL_LVL_W-1:0]     rx_lvl;
	logic [SFL_LVL_W-1:0]     tx_lvl;
	logic [SFL_LVL_W-1:0]     rx_thr_b;
	logic [SFL_LVL_W-1:0]     tx_thr_b;
	logic                     rx_full;
	logic                     rx_empty;
	logic                     tx_full;
	logic                     tx_empty;
	logic [7:0]               rx_head;
	logic [7:0]               tx_head;
	logic                     rx_hit;
	logic                     tx_hit;
	logic                     ovr_set;
	logic                     und_set;
	logic [SFL_IRQ_N-1:0]     irq_set;
	logic [SFL_IRQ_N-1:0]     irq_stat;
	logic [SFL_IRQ_N-1:0]     irq_mask;

	if (DEPTH != 4) begin : g_bad_depth
		$error("sfl_top: DEPTH must be 4 to match the level field");
	end

	// Address decode
	function automatic sfl_reg_e dec(input logic [SFL_ADDR_W-1:0] a);
		sfl_reg_e r;
		r = SFL_R_NONE;
		if (a == SFL_OFF_RX_CFG) begin
			r = SFL_R_RX_CFG;
		end else if (a == SFL_OFF_TX_CFG) begin
			r = SFL_R_TX_CFG;
		end else if (a == SFL_OFF_RX_ST) begin
			r = SFL_R_RX_ST;
		end else if (a == SFL_OFF_TX_ST) begin
			r = SFL_R_TX_ST;
		end else if (a == SFL_OFF_DATA) begin
			r = SFL_R_DATA;
		end else if (a == SFL_OFF_ISTAT) begin
			r = SFL_R_ISTAT;
		end else if (a == SFL_OFF_IMASK) begin
			r = SFL_R_IMASK;
		end
		return r;
	endfunction

	// Threshold compare, equal or ordered
	function automatic logic hit(input logic [2:0] l, input logic [2:0] t,
		input logic m, input logic le);
		if (!m) return l == t;
		return le ? (l <= t) : (l >= t);
	endfunction

	// Strobes from the register port
	always_comb begin
		sel       = dec(reg_addr);
		wr_rx_cfg = reg_wr && (sel == SFL_R_RX_CFG);
		wr_tx_cfg = reg_wr && (sel == SFL_R_TX_CFG);
		wr_data   = reg_wr && (sel == SFL_R_DATA);
		rd_data   = reg_rd && (sel == SFL_R_DATA);
		rx_clr    = wr_rx_cfg && reg_wdata[SFL_BIT_CLR];
		tx_clr    = wr_tx_cfg && reg_wdata[SFL_BIT_CLR];
	end

	// Sizing; a mode change is followed by a clear from software
	always_comb begin
		fe      = fifo_enable && !nine_bit_mode;
		tx_stop = !channel_run || (idle_mode && !run_in_idle);
		if (!fe) begin
			rx_cap = SFL_CAP_OFF;
			tx_cap = SFL_CAP_OFF;
		end else if (full_duplex) begin
			rx_cap = SFL_CAP_FULL;
			tx_cap = SFL_CAP_FULL;
		end else begin
			rx_cap = SFL_CAP_HALF;
			tx_cap = SFL_CAP_HALF;
		end
	end

	// Threshold conditions
	always_comb begin
		rx_thr_b = sfl_rx_thr(st_ff.rx_thr, full_duplex);
		tx_thr_b = sfl_tx_thr(st_ff.tx_thr, full_duplex);
		rx_hit   = fe && hit(rx_lvl, rx_thr_b, st_ff.rx_cmp, 1'b0);
		tx_hit   = fe && hit(tx_lvl, tx_thr_b, st_ff.tx_cmp, 1'b1);
		ovr_set  = rx_push && rx_full;
		und_set  = tx_pop && tx_empty;
		irq_set  = '0;
		irq_set[SFL_IRQ_RX_THR] = rx_hit && !st_ff.rx_hit;
		irq_set[SFL_IRQ_TX_THR] = tx_hit && !st_ff.tx_hit;
		irq_set[SFL_IRQ_RX_OVR] = ovr_set;
		irq_set[SFL_IRQ_TX_UND] = und_set;
	end

	// Receive FIFO
	sfl_fifo #(
		.WIDTH (8),
		.DEPTH (DEPTH)
	) u_rx_fifo (
		.core_clk  (core_clk),
		.rst_b     (rst_b),
		.clr       (rx_clr),
		.cap       (rx_cap),
		.push      (rx_push),
		.push_data (rx_push_data),
		.pop       (rd_data),
		.head      (rx_head),
		.level     (rx_lvl),
		.full      (rx_full),
		.empty     (rx_empty)
	);

	// Transmit FIFO
	sfl_fifo #(
		.WIDTH (8),
		.DEPTH (DEPTH)
	) u_tx_fifo (
		.core_clk  (core_clk),
		.rst_b     (rst_b),
		.clr       (tx_clr),
		.cap       (tx_cap),
		.push      (wr_data),
		.push_data (reg_wdata[7:0]),
		.pop       (tx_pop),
		.head      (tx_head),
		.level     (tx_lvl),
		.full      (tx_full),
		.empty     (tx_empty)
	);

	// Interrupt status and mask
	sfl_irq #(
		.N (SFL_IRQ_N)
	) u_irq (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.set      (irq_set),
		.wr_stat  (reg_wr && (sel == SFL_R_ISTAT)),
		.wr_mask  (reg_wr && (sel == SFL_R_IMASK)),
		.wdata    (reg_wdata[SFL_IRQ_N-1:0]),
		.stat     (irq_stat),
		.mask     (irq_mask),
		.irq      (irq_ff)
	);

	// Configuration, flags, read data and transmit output
	always_comb begin
		nxt_st        = st_ff;
		nxt_st.rx_hit = rx_hit;
		nxt_st.tx_hit = tx_hit;
		if (wr_rx_cfg) begin
			nxt_st.rx_cmp = reg_wdata[SFL_BIT_CMP];
			nxt_st.rx_thr = reg_wdata[1:0];
		end
		if (tx_stop) begin
			nxt_st.tx_cmp = 1'b0;
			nxt_st.tx_thr = 2'h0;
		end else if (wr_tx_cfg) begin
			nxt_st.tx_cmp = reg_wdata[SFL_BIT_CMP];
			nxt_st.tx_thr = reg_wdata[1:0];
		end
		// Overrun set wins over the read that clears it
		nxt_st.rx_ovr = ovr_set || (st_ff.rx_ovr && !rd_data);
		nxt_st.tx_und = und_set || (st_ff.tx_und && !wr_data);
		// Refresh after a pop waits one cycle
		nxt_st.tx_data = tx_head;
		nxt_st.tx_rdy  = !tx_empty && !tx_pop;
		nxt_st.rdata   = 32'h0;
		if (reg_rd) begin
			if (sel == SFL_R_RX_CFG) begin
				nxt_st.rdata[SFL_BIT_CMP] = st_ff.rx_cmp;
				nxt_st.rdata[1:0]         = st_ff.rx_thr;
			end else if (sel == SFL_R_TX_CFG) begin
				nxt_st.rdata[SFL_BIT_CMP] = st_ff.tx_cmp;
				nxt_st.rdata[1:0]         = st_ff.tx_thr;
			end else if (sel == SFL_R_RX_ST) begin
				nxt_st.rdata[SFL_BIT_FLAG] = st_ff.rx_ovr;
				nxt_st.rdata[2:0]          = rx_lvl;
			end else if (sel == SFL_R_TX_ST) begin
				nxt_st.rdata[SFL_BIT_FLAG] = st_ff.tx_und;
				nxt_st.rdata[2:0]          = tx_lvl;
			end else if (sel == SFL_R_DATA) begin
				nxt_st.rdata[7:0] = rx_empty ? 8'h00 : rx_head;
			end else if (sel == SFL_R_ISTAT) begin
				nxt_st.rdata[SFL_IRQ_N-1:0] = irq_stat;
			end else if (sel == SFL_R_IMASK) begin
				nxt_st.rdata[SFL_IRQ_N-1:0] = irq_mask;
			end
		end
	end

	// State register
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_ff <= TOP_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign reg_rdata_ff = st_ff.rdata;
	assign tx_data_ff   = st_ff.tx_data;
	assign tx_ready_ff  = st_ff.tx_rdy;

	// Checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	a_rx_clear_lvl: assert property (
		rx_clr |=> rx_lvl == SFL_LVL_EMPTY)
		else $error("rx clear left data");

	a_rx_eq_fire: assert property (
		fe && !st_ff.rx_cmp && !st_ff.rx_hit && rx_lvl == rx_thr_b
		|=> irq_stat[SFL_IRQ_RX_THR])
		else $error("rx equal event missed");

	a_rx_ge_fire: assert property (
		fe && st_ff.rx_cmp && !st_ff.rx_hit && rx_lvl >= rx_thr_b
		|=> irq_stat[SFL_IRQ_RX_THR])
		else $error("rx at-or-above event missed");

	a_rx_thr_map: assert property (
		!full_duplex && st_ff.rx_thr == 2'h0 && !st_ff.rx_cmp && rx_hit
		|-> rx_lvl == 3'h4)
		else $error("rx half duplex code 00 not four bytes");

	a_tx_clear_lvl: assert property (
		tx_clr |=> tx_lvl == SFL_LVL_EMPTY ##1 !tx_ready_ff)
		else $error("tx clear left data");

	a_tx_le_fire: assert property (
		fe && st_ff.tx_cmp && !st_ff.tx_hit && tx_lvl <= tx_thr_b
		|=> irq_stat[SFL_IRQ_TX_THR])
		else $error("tx at-or-below event missed");

	a_tx_thr_map: assert property (
		full_duplex && st_ff.tx_thr == 2'h2 && !st_ff.tx_cmp && tx_hit
		|-> tx_lvl == 3'h0)
		else $error("tx full duplex code 10 not empty");

	a_tx_cfg_stop: assert property (
		tx_stop |=> !st_ff.tx_cmp && st_ff.tx_thr == 2'h0)
		else $error("tx config kept while stopped");

	a_ovr_sticky: assert property (
		ovr_set |=> st_ff.rx_ovr)
		else $error("overrun flag not set");

	a_ovr_clear: assert property (
		st_ff.rx_ovr && rd_data && !ovr_set |=> !st_ff.rx_ovr)
		else $error("overrun flag not cleared by data read");

	a_rx_lvl_step: assert property (
		rx_push && !rx_full && !rx_clr && !rd_data
		|=> rx_lvl == $past(rx_lvl) + 3'h1)
		else $error("rx level did not count the byte");

	a_nine_off: assert property (
		nine_bit_mode |-> rx_cap == SFL_CAP_OFF && !rx_hit && !tx_hit)
		else $error("fifo active in nine-bit format");

	a_tx_eq_only: assert property (
		$rose(irq_stat[SFL_IRQ_TX_THR]) && !$past(st_ff.tx_cmp)
		|-> $past(tx_lvl) == $past(tx_thr_b))
		else $error("tx equal event at wrong level");

	a_cfg_read_zero: assert property (
		reg_rd && (sel == SFL_R_RX_CFG || sel == SFL_R_TX_CFG)
		|=> reg_rdata_ff[31:7] == 25'h0 && reg_rdata_ff[5:2] == 4'h0)
		else $error("clear or unused bit read as one");

	c_rx_full4: cover property (rx_lvl == 3'h4);
	c_rx_overrun: cover property (ovr_set ##1 rd_data);
	c_tx_clear: cover property (!tx_empty ##1 tx_clr);
	c_irq_high: cover property ($rose(irq_ff));
endmodule // sfl_top
`default_nettype wire

//--- include/sfl_pkg.sv
// Constants, register layout and decode helpers of the serial FIFO level control
// Notes on behaviour
// - A receive clear strobe empties the receive FIFO, zeroes its level and resets its read side.
// - Receive event fires at level equal to threshold (mode 0) or at or above it (mode 1).
// - Receive threshold 00/01/10/11 is 4/1/2/3 bytes half duplex; 00 is 2 and 01 is 1 full duplex.
// - A transmit clear strobe empties the transmit FIFO, zeroes its level and resets its write side.
// - With transmit compare mode 1 the event fires at level at or below the threshold.
// - Transmit threshold 00/01/10/11 is empty/1/2/3 bytes half duplex; empty/1 byte full duplex.
// - Transmit configuration resets while the channel is stopped or idles without run-in-idle.
// - A receive overflow sets the sticky overrun flag in bit 7; a data buffer read clears it.
// - The receive level field reads 0 for empty and 1 to 4 for one to four bytes.
// - In nine-bit UART format the FIFOs stay out of use.
package sfl_pkg;
	// Register offsets
	localparam int         SFL_ADDR_W     = 8;
	localparam logic [7:0] SFL_OFF_RX_CFG = 8'h00;
	localparam logic [7:0] SFL_OFF_TX_CFG = 8'h04;
	localparam logic [7:0] SFL_OFF_RX_ST  = 8'h08;
	localparam logic [7:0] SFL_OFF_TX_ST  = 8'h0C;
	localparam logic [7:0] SFL_OFF_DATA   = 8'h10;
	localparam logic [7:0] SFL_OFF_ISTAT  = 8'h14;
	localparam logic [7:0] SFL_OFF_IMASK  = 8'h18;
	// Field positions
	localparam int SFL_BIT_CLR  = 7;
	localparam int SFL_BIT_CMP  = 6;
	localparam int SFL_BIT_FLAG = 7;
	localparam int SFL_LVL_W    = 3;
	// Levels and capacities
	localparam logic [2:0] SFL_LVL_EMPTY = 3'h0;
	localparam logic [2:0] SFL_CAP_HALF  = 3'h4;
	localparam logic [2:0] SFL_CAP_FULL  = 3'h2;
	localparam logic [2:0] SFL_CAP_OFF   = 3'h1;
	// Reset values
	localparam logic       SFL_TX_UND_RST = 1'b1;
	localparam logic [3:0] SFL_IRQ_RST    = 4'h0;
	// Interrupt bits
	localparam int SFL_IRQ_N      = 4;
	localparam int SFL_IRQ_RX_THR = 0;
	localparam int SFL_IRQ_TX_THR = 1;
	localparam int SFL_IRQ_RX_OVR = 2;
	localparam int SFL_IRQ_TX_UND = 3;
	// Decoded register
	typedef enum {
		SFL_R_RX_CFG, SFL_R_TX_CFG, SFL_R_RX_ST, SFL_R_TX_ST,
		SFL_R_DATA, SFL_R_ISTAT, SFL_R_IMASK, SFL_R_NONE
	} sfl_reg_e;
	// Receive threshold in bytes
	function automatic logic [2:0] sfl_rx_thr(input logic [1:0] s, input logic fd);
		if (fd) return s[0] ? 3'h1 : 3'h2;
		return (s == 2'h0) ? 3'h4 : {1'b0, s};
	endfunction
	// Transmit threshold in bytes
	function automatic logic [2:0] sfl_tx_thr(input logic [1:0] s, input logic fd);
		if (fd) return {2'h0, s[0]};
		return {1'b0, s};
	endfunction
endpackage

//--- verif/sfl_shift_model.sv
// Behavioural shift register side: pushes received bytes, takes transmit bytes
`timescale 1ns/1ps
`default_nettype none
module sfl_shift_model (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst_b,
	// Commands from the bench
	input  wire logic       push_go,
	input  wire logic [7:0] push_byte,
	input  wire logic       pop_go,
	// Receive side toward the block
	output logic            rx_push,
	output logic      [7:0] rx_push_data,
	// Transmit side from the block
	input  wire logic       tx_ready_ff,
	input  wire logic [7:0] tx_data_ff,
	output logic            tx_pop,
	output logic      [7:0] last_pop_ff
);
	logic [3:0] pend_ff;
	// One-cycle push; between pushes the data lines keep changing
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_push      <= 1'b0;
			rx_push_data <= 8'h5A;
		end else begin
			rx_push      <= push_go;
			rx_push_data <= push_go ? push_byte : ~rx_push_data;
		end
	end
	// Pop only a ready byte, never in two adjacent cycles
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pend_ff     <= 4'h0;
			tx_pop      <= 1'b0;
			last_pop_ff <= 8'h00;
		end else if (pend_ff != 4'h0 && tx_ready_ff && !tx_pop) begin
			tx_pop      <= 1'b1;
			pend_ff     <= pend_ff - 4'h1 + {3'h0, pop_go};
			last_pop_ff <= tx_data_ff;
		end else begin
			tx_pop  <= 1'b0;
			pend_ff <= pend_ff + {3'h0, pop_go};
		end
	end
endmodule // sfl_shift_model
`default_nettype wire

//--- verif/tb.sv
// Self-checking bench of the serial FIFO level control
`timescale 1ns/1ps
`default_nettype none
module tb;
	import sfl_pkg::*;
	typedef struct packed {
		logic       fd;
		logic       nb;
		logic [7:0] cfg;
		logic [3:0] n;
		logic [7:0] st;
		logic [7:0] ist;
	} sfl_row_s;
	logic        core_clk, rst_b, reg_wr, reg_rd, irq_ff;
	logic [7:0]  reg_addr, rx_push_data, tx_data_ff, push_byte, last_pop;
	logic [31:0] reg_wdata, reg_rdata_ff;
	logic        fifo_enable, full_duplex, nine_bit_mode, channel_run, idle_mode, run_in_idle;
	logic        rx_push, tx_pop, tx_ready_ff, push_go, pop_go;
	int          fails, n_tests;
	sfl_row_s    rows [10];

	sfl_top #(.DEPTH(4)) u_sfl_top (
		.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
		.fifo_enable(fifo_enable), .full_duplex(full_duplex), .nine_bit_mode(nine_bit_mode),
		.channel_run(channel_run), .idle_mode(idle_mode), .run_in_idle(run_in_idle),
		.rx_push(rx_push), .rx_push_data(rx_push_data), .tx_pop(tx_pop),
		.tx_data_ff(tx_data_ff), .tx_ready_ff(tx_ready_ff), .irq_ff(irq_ff));
	sfl_shift_model u_sfl_shift_model (
		.core_clk(core_clk), .rst_b(rst_b), .push_go(push_go), .push_byte(push_byte),
		.pop_go(pop_go), .rx_push(rx_push), .rx_push_data(rx_push_data),
		.tx_ready_ff(tx_ready_ff), .tx_data_ff(tx_data_ff), .tx_pop(tx_pop),
		.last_pop_ff(last_pop));

	// Clock
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	// Read one register, compare the masked data in the cycle after the strobe
	task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp,
			input string nm);
		@(posedge core_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 chk(nm, exp, reg_rdata_ff & m);
	endtask
	task automatic push(input logic [7:0] b);
		@(posedge core_clk);
		push_go   <= 1'b1;
		push_byte <= b;
		@(posedge core_clk);
		push_go <= 1'b0;
	endtask
	task automatic pop();
		@(posedge core_clk);
		pop_go <= 1'b1;
		@(posedge core_clk);
		pop_go <= 1'b0;
	endtask
	task automatic settle();
		repeat (4) @(posedge core_clk);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Watchdog
	initial begin
		#(8 * 20000);
		fails++;
		$display("[FAIL] watchdog expected finish seen hang");
		print_verdict();
	end

	// Main sequence
	initial begin
		fails = 0;
		n_tests = 0;
		{reg_wr, reg_rd, push_go, pop_go, idle_mode, run_in_idle} = 6'h00;
		{reg_addr, reg_wdata, push_byte} = 48'h0;
		{fifo_enable, full_duplex, nine_bit_mode, channel_run} = 4'h9;
		rows = '{'{1'b0, 1'b0, 8'h40, 4'h3, 8'h03, 8'h00}, '{1'b0, 1'b0, 8'h40, 4'h4, 8'h04, 8'h01},
			'{1'b0, 1'b0, 8'h01, 4'h1, 8'h01, 8'h01}, '{1'b0, 1'b0, 8'h02, 4'h1, 8'h01, 8'h00},
			'{1'b0, 1'b0, 8'h43, 4'h3, 8'h03, 8'h01}, '{1'b0, 1'b0, 8'h40, 4'h5, 8'h84, 8'h05},
			'{1'b1, 1'b0, 8'h00, 4'h1, 8'h81, 8'h00}, '{1'b1, 1'b0, 8'h40, 4'h2, 8'h82, 8'h01},
			'{1'b1, 1'b0, 8'h01, 4'h3, 8'h82, 8'h05}, '{1'b0, 1'b1, 8'h01, 4'h2, 8'h81, 8'h04}};
		rst_b = 1'b0;
		repeat (2) @(posedge core_clk);
		rst_b <= 1'b1;
		// Reset values and an unmapped place
		rdc(SFL_OFF_RX_CFG, 32'hFFFFFFFF, 32'h0, "rx_fifo_config");
		rdc(SFL_OFF_TX_CFG, 32'hFFFFFFFF, 32'h0, "tx_fifo_config");
		rdc(SFL_OFF_RX_ST, 32'hFFFFFFFF, 32'h0, "rx_fifo_status");
		rdc(SFL_OFF_TX_ST, 32'hFFFFFFFF, 32'h80, "tx_fifo_status");
		rdc(SFL_OFF_IMASK, 32'hFFFFFFFF, 32'h0, "irq_mask");
		rdc(8'h1C, 32'hFFFFFFFF, 32'h0, "unmapped");
		// Receive threshold, level and overrun rows
		foreach (rows[i]) begin
			@(posedge core_clk);
			full_duplex   <= rows[i].fd;
			nine_bit_mode <= rows[i].nb;
			wr(SFL_OFF_RX_CFG, {24'h0, rows[i].cfg | 8'h80});
			wr(SFL_OFF_ISTAT, 32'hF);
			repeat (rows[i].n) push(8'h20 + 8'(i));
			settle();
			rdc(SFL_OFF_RX_ST, 32'hFFFFFFFF, {24'h0, rows[i].st}, "rx_level");
			rdc(SFL_OFF_ISTAT, 32'h5, {24'h0, rows[i].ist}, "rx_irq");
			rdc(SFL_OFF_RX_CFG, 32'hFFFFFFFF, {24'h0, rows[i].cfg}, "rx_cfg");
		end
		@(posedge core_clk);
		full_duplex   <= 1'b0;
		nine_bit_mode <= 1'b0;
		// Compare mode switched while the level stands above the threshold
		wr(SFL_OFF_RX_CFG, 32'h81);
		repeat (3) push(8'h31);
		settle();
		wr(SFL_OFF_ISTAT, 32'hF);
		wr(SFL_OFF_RX_CFG, 32'h41);
		rdc(SFL_OFF_ISTAT, 32'h1, 32'h1, "rx_irq_ge");
		wr(SFL_OFF_ISTAT, 32'h1);
		wr(SFL_OFF_RX_CFG, 32'h01);
		rdc(SFL_OFF_ISTAT, 32'h1, 32'h0, "rx_irq_eq");
		// Overrun, data order, interrupt mask and clear
		wr(SFL_OFF_IMASK, 32'h4);
		wr(SFL_OFF_RX_CFG, 32'h80);
		for (int k = 1; k <= 5; k++) push(8'h10 + 8'(k));
		settle();
		chk("irq_ff_set", 32'h1, {31'h0, irq_ff});
		rdc(SFL_OFF_DATA, 32'hFF, 32'h11, "rx_data");
		rdc(SFL_OFF_RX_ST, 32'hFFFFFFFF, 32'h03, "ovr_cleared");
		rdc(SFL_OFF_IMASK, 32'hFFFFFFFF, 32'h4, "irq_mask");
		wr(SFL_OFF_ISTAT, 32'h4);
		settle();
		chk("irq_ff_clr", 32'h0, {31'h0, irq_ff});
		wr(SFL_OFF_RX_CFG, 32'h80);
		rdc(SFL_OFF_RX_ST, 32'hFFFFFFFF, 32'h0, "rx_cleared");
		// Transmit threshold at or below, then exactly equal
		wr(SFL_OFF_TX_CFG, 32'hC1);
		for (int k = 1; k <= 3; k++) wr(SFL_OFF_DATA, 32'hA0 + k);
		settle();
		wr(SFL_OFF_ISTAT, 32'hF);
		rdc(SFL_OFF_TX_ST, 32'hFFFFFFFF, 32'h03, "tx_level");
		rdc(SFL_OFF_ISTAT, 32'h2, 32'h0, "tx_irq_lvl3");
		pop();
		settle();
		chk("tx_pop1", 32'hA1, {24'h0, last_pop});
		rdc(SFL_OFF_ISTAT, 32'h2, 32'h0, "tx_irq_lvl2");
		pop();
		settle();
		chk("tx_pop2", 32'hA2, {24'h0, last_pop});
		rdc(SFL_OFF_ISTAT, 32'h2, 32'h2, "tx_irq_lvl1");
		wr(SFL_OFF_ISTAT, 32'hF);
		wr(SFL_OFF_TX_CFG, 32'h02);
		rdc(SFL_OFF_ISTAT, 32'h2, 32'h0, "tx_irq_ne");
		wr(SFL_OFF_DATA, 32'hB4);
		settle();
		rdc(SFL_OFF_ISTAT, 32'h2, 32'h2, "tx_irq_eq");
		wr(SFL_OFF_TX_CFG, 32'h80);
		rdc(SFL_OFF_TX_ST, 32'hFFFFFFFF, 32'h0, "tx_cleared");
		// Full duplex code 10 means empty
		@(posedge core_clk);
		full_duplex <= 1'b1;
		wr(SFL_OFF_TX_CFG, 32'h01);
		wr(SFL_OFF_ISTAT, 32'hF);
		wr(SFL_OFF_TX_CFG, 32'h02);
		rdc(SFL_OFF_ISTAT, 32'h2, 32'h2, "tx_irq_fd_empty");
		@(posedge core_clk);
		full_duplex <= 1'b0;
		// Transmit configuration held at reset when stopped or idle without run-in-idle
		wr(SFL_OFF_TX_CFG, 32'h42);
		rdc(SFL_OFF_TX_CFG, 32'hFFFFFFFF, 32'h42, "tx_cfg");
		@(posedge core_clk);
		channel_run <= 1'b0;
		settle();
		rdc(SFL_OFF_TX_CFG, 32'hFFFFFFFF, 32'h0, "tx_cfg_stop");
		@(posedge core_clk);
		channel_run <= 1'b1;
		wr(SFL_OFF_TX_CFG, 32'h42);
		idle_mode <= 1'b1;
		settle();
		rdc(SFL_OFF_TX_CFG, 32'hFFFFFFFF, 32'h0, "tx_cfg_idle");
		@(posedge core_clk);
		run_in_idle <= 1'b1;
		wr(SFL_OFF_TX_CFG, 32'h42);
		settle();
		rdc(SFL_OFF_TX_CFG, 32'hFFFFFFFF, 32'h42, "tx_cfg_run_idle");
		@(posedge core_clk);
		idle_mode <= 1'b0;
		// Second reset in mid-run
		@(posedge core_clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_b <= 1'b1;
		rdc(SFL_OFF_TX_ST, 32'hFFFFFFFF, 32'h80, "tx_st_reset");
		rdc(SFL_OFF_TX_CFG, 32'hFFFFFFFF, 32'h0, "tx_cfg_reset");
		print_verdict();
	end
endmodule // tb
`default_nettype wire
